//--- rtl/ueg_pkg.sv
/*
  Constants for the unintended energize guard: register map, field
  layout, setting reset values, ranges, timing and the state type.
  Assumes a 25 MHz system clock and a 32-bit register port.
*/
package ueg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UEG_CLK_HZ = 25_000_000;
  localparam int UEG_CYCLE_MS = 5;
  localparam int UEG_STAMP_MS = 1;
  localparam int UEG_TICK_CYCLES = UEG_CLK_HZ / 1000 * UEG_CYCLE_MS;
  localparam int UEG_MS_CYCLES = UEG_CLK_HZ / 1000 * UEG_STAMP_MS;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] UEG_A_CTRL = 8'h00;
  localparam logic [7:0] UEG_A_EDITGRP = 8'h04;
  localparam logic [7:0] UEG_A_UVLIM = 8'h08;
  localparam logic [7:0] UEG_A_CURLIM = 8'h0C;
  localparam logic [7:0] UEG_A_ACTDLY = 8'h10;
  localparam logic [7:0] UEG_A_RELDLY = 8'h14;
  localparam logic [7:0] UEG_A_STATUS = 8'h18;
  localparam logic [7:0] UEG_A_EXPTIME = 8'h1C;
  localparam logic [7:0] UEG_A_REMTIME = 8'h20;
  localparam logic [7:0] UEG_A_VRATIO = 8'h24;
  localparam logic [7:0] UEG_A_IRATIO = 8'h28;
  localparam logic [7:0] UEG_A_LOGSEL = 8'h2C;
  localparam logic [2:0] UEG_A_LOGWIN = 3'h2;

  // ----------------------------------------------------------------
  // Control fields and codes
  // ----------------------------------------------------------------
  localparam int UEG_F_FORCE_EN = 3;
  localparam int UEG_F_STORE_ON = 6;
  localparam int UEG_F_STORE_OFF = 7;
  localparam logic [7:0] UEG_CTRL_RST = 8'hC1;
  localparam logic [2:0] UEG_MODE_ON = 3'h1;
  localparam logic [2:0] UEG_MODE_BLK = 3'h2;
  localparam logic [2:0] UEG_MODE_TESTBLK = 3'h4;
  localparam logic [2:0] UEG_MODE_OFF = 3'h5;
  localparam logic [1:0] UEG_COND_NORMAL = 2'h0;
  localparam logic [1:0] UEG_COND_START = 2'h1;
  localparam logic [1:0] UEG_COND_TRIP = 2'h2;
  localparam logic [1:0] UEG_COND_BLOCKED = 2'h3;

  // ----------------------------------------------------------------
  // Settings: voltage in 0.01 %Un, current in 0.05 xIn steps,
  // delays in 5 ms ticks
  // ----------------------------------------------------------------
  localparam logic [15:0] UEG_UV_RST = 16'h1388;
  localparam logic [15:0] UEG_UV_MAX = 16'h26AC;
  localparam logic [5:0] UEG_CUR_RST = 6'h01;
  localparam logic [5:0] UEG_CUR_MAX = 6'h3C;
  localparam logic [15:0] UEG_CUR_UNIT = 16'h0005;
  localparam logic [18:0] UEG_ACT_RST = 19'h003E8;
  localparam logic [18:0] UEG_REL_RST = 19'h00032;
  localparam logic [18:0] UEG_DLY_MAX = 19'h57E40;
  localparam logic [23:0] UEG_RATIO_SCALE = 24'h000064;
  localparam logic [23:0] UEG_RATIO_MAX = 24'h01E848;
  localparam logic [3:0] UEG_LOG_DEPTH = 4'hC;
  localparam logic [4:0] UEG_LOG_LAST = 5'h0B;

  typedef enum logic [1:0] {UEG_IDLE, UEG_ARMING, UEG_STARTED, UEG_RELEASING} ueg_state_t;

endpackage

//--- rtl/ueg_energize_block.sv
/*
  Unintended energize guard: undervoltage-armed start with activation
  and release delays, all-phase overcurrent trip, blocking, forcing,
  read-outs, ON/OFF events and a twelve-entry ON-event log.
  Assumes measurements come from logic on mclk and hold between
  refreshes; the blocking input may come from anywhere.
*/
// Operation
// - Undervoltage waits activation delay before start
// - Recovery holds start for release delay
// - Start plus all currents over limit trips
// - Voltage limit 0-99 percent, default 50
// - Current limit 0.05-3.00, checked per phase
// - Blocking sampled at each cycle start
// - Unblocked pick-up gives start output
// - Blocked pick-up gives blocked, no trip
// - Blocking drops start, runs release timing
// - Blocking raises notification and stamped event
// - ON/OFF events per output, masked storing
// - Log keeps newest twelve ON events
// - Entry: stamp, id, currents, voltages, group
// - Condition code normal/start/trip/blocked
// - Behaviour code on/blocked/test/testblk/off
// - Signed remaining time in 5 ms units
// - Expected operating time in 5 ms units
// - Voltage to setting ratio, 0.01 steps
// - Minimum current to setting ratio
// - RMS inputs refreshed every 5 ms
// - 1 ms stamps, start and trip shared
// - Forcing overrides condition codes 0-3
// - Eight setting groups, one selector
`timescale 1ns/1ps
module ueg_energize_block
  import ueg_pkg::*;
#(
  parameter int TICK_CYCLES = UEG_TICK_CYCLES,
  parameter int MS_CYCLES = UEG_MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdata,
  input wire logic [15:0] phaseACurrentRms,
  input wire logic [15:0] phaseBCurrentRms,
  input wire logic [15:0] phaseCCurrentRms,
  input wire logic [15:0] posSeqVoltage,
  input wire logic [15:0] voltageAb,
  input wire logic [15:0] voltageBc,
  input wire logic [15:0] voltageCa,
  input wire logic [2:0] settingGroup,
  input wire logic blockIn,
  output logic startOut,
  output logic tripOut,
  output logic blockedOut,
  output logic eventStrobe,
  output logic [2:0] eventOn,
  output logic [2:0] eventOff,
  output logic [31:0] eventStamp,
  output logic blockNotify
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [18:0] clampDelay(input logic [31:0] v);
    clampDelay = (v > 32'(UEG_DLY_MAX)) ? UEG_DLY_MAX : v[18:0];
  endfunction

  // Result saturates at the top of the reporting range
  function automatic logic [16:0] ratioOf(input logic [15:0] num, input logic [15:0] den);
    logic [23:0] q;
    q = UEG_RATIO_MAX;
    if (den != 16'h0000) begin
      q = (24'(num) * UEG_RATIO_SCALE) / 24'(den);
    end
    if (q > UEG_RATIO_MAX) begin
      q = UEG_RATIO_MAX;
    end
    ratioOf = q[16:0];
  endfunction

  // ----------------------------------------------------------------
  // Processing cycle tick and millisecond stamp
  // ----------------------------------------------------------------
  logic [31:0] tickCnt;
  logic [31:0] msCnt;
  logic [31:0] msStamp;
  wire tick = (tickCnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      tickCnt <= 32'h0;
    end else begin
      tickCnt <= tick ? 32'h0 : tickCnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      msCnt <= 32'h0;
      msStamp <= 32'h0;
    end else if (msCnt == 32'(MS_CYCLES - 1)) begin
      msCnt <= 32'h0;
      msStamp <= msStamp + 32'h1;
    end else begin
      msCnt <= msCnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Blocking input synchroniser
  // ----------------------------------------------------------------
  logic blkMeta;
  logic blkSync;

  always_ff @(posedge mclk) begin
    if (rst) begin
      blkMeta <= 1'b0;
      blkSync <= 1'b0;
    end else begin
      blkMeta <= blockIn;
      blkSync <= blkMeta;
    end
  end

  // ----------------------------------------------------------------
  // Control and setting groups
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [2:0] editGrp;
  logic [3:0] logSel;
  logic [15:0] uvSet [0:7];
  logic [5:0] curSet [0:7];
  logic [18:0] actSet [0:7];
  logic [18:0] relSet [0:7];

  wire [2:0] mode = ctrl[2:0];
  wire forceEn = ctrl[UEG_F_FORCE_EN];
  wire [1:0] forceCode = ctrl[5:4];
  wire wrCtrl = wrEn && addr == UEG_A_CTRL;
  wire [31:0] curClamp = (wdata > 32'(UEG_CUR_MAX)) ? 32'(UEG_CUR_MAX) : wdata;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= UEG_CTRL_RST;
      editGrp <= 3'h0;
      logSel <= 4'h0;
      for (int g = 0; g < 8; g++) begin
        uvSet[g] <= UEG_UV_RST;
        curSet[g] <= UEG_CUR_RST;
        actSet[g] <= UEG_ACT_RST;
        relSet[g] <= UEG_REL_RST;
      end
    end else if (wrEn) begin
      if (wrCtrl) begin
        ctrl <= wdata[7:0];
      end
      if (addr == UEG_A_EDITGRP) begin
        editGrp <= wdata[2:0];
      end
      if (addr == UEG_A_UVLIM) begin
        uvSet[editGrp] <= (wdata > 32'(UEG_UV_MAX)) ? UEG_UV_MAX : wdata[15:0];
      end
      if (addr == UEG_A_CURLIM) begin
        curSet[editGrp] <= (wdata == 32'h0) ? UEG_CUR_RST : curClamp[5:0];
      end
      if (addr == UEG_A_ACTDLY) begin
        actSet[editGrp] <= clampDelay(wdata);
      end
      if (addr == UEG_A_RELDLY) begin
        relSet[editGrp] <= clampDelay(wdata);
      end
      if (addr == UEG_A_LOGSEL) begin
        logSel <= (wdata[3:0] >= UEG_LOG_DEPTH) ? 4'h0 : wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparators on the active group
  // ----------------------------------------------------------------
  wire [15:0] uvLimit = uvSet[settingGroup];
  wire [15:0] curLimit = 16'(curSet[settingGroup]) * UEG_CUR_UNIT;
  wire [18:0] actDelay = actSet[settingGroup];
  wire [18:0] relDelay = relSet[settingGroup];
  wire modeOff = (mode == UEG_MODE_OFF);
  wire blk = blkSync || mode == UEG_MODE_BLK || mode == UEG_MODE_TESTBLK;
  wire uvCond = posSeqVoltage < uvLimit;
  wire relCond = !uvCond || blk;
  wire allOver = phaseACurrentRms > curLimit && phaseBCurrentRms > curLimit
    && phaseCCurrentRms > curLimit;
  wire [15:0] minAB = (phaseACurrentRms < phaseBCurrentRms) ? phaseACurrentRms : phaseBCurrentRms;
  wire [15:0] minCur = (phaseCCurrentRms < minAB) ? phaseCCurrentRms : minAB;

  // ----------------------------------------------------------------
  // Start condition timing, one step per processing cycle
  // ----------------------------------------------------------------
  ueg_state_t state;
  logic [18:0] timer;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= UEG_IDLE;
      timer <= 19'h0;
    end else if (tick) begin
      if (modeOff) begin
        state <= UEG_IDLE;
        timer <= 19'h0;
      end else begin
        case (state)
          UEG_IDLE: begin
            timer <= 19'h1;
            if (uvCond) begin
              state <= (actDelay == 19'h0) ? UEG_STARTED : UEG_ARMING;
            end
          end
          UEG_ARMING: begin
            if (!uvCond) begin
              state <= UEG_IDLE;
            end else if (timer >= actDelay) begin
              state <= UEG_STARTED;
            end else begin
              timer <= timer + 19'h1;
            end
          end
          UEG_STARTED: begin
            timer <= 19'h1;
            if (relCond) begin
              state <= (relDelay == 19'h0) ? UEG_IDLE : UEG_RELEASING;
            end
          end
          UEG_RELEASING: begin
            if (!relCond) begin
              state <= UEG_STARTED;
            end else if (timer >= relDelay) begin
              state <= UEG_IDLE;
            end else begin
              timer <= timer + 19'h1;
            end
          end
          default: begin
            state <= UEG_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Output decision
  // ----------------------------------------------------------------
  // Trip stays live through the release countdown, not only while low
  wire startCond = state == UEG_STARTED || state == UEG_RELEASING;
  wire pickUp = (uvCond || startCond) && !modeOff;
  wire calcStart = startCond && !blk && !modeOff;
  wire calcTrip = calcStart && allOver;
  wire calcBlocked = pickUp && blk;
  wire next_start = forceEn ? (forceCode == UEG_COND_START || forceCode == UEG_COND_TRIP)
    : calcStart;
  wire next_trip = forceEn ? (forceCode == UEG_COND_TRIP) : calcTrip;
  wire next_blocked = forceEn ? (forceCode == UEG_COND_BLOCKED) : calcBlocked;
  wire [2:0] curOuts = {blockedOut, tripOut, startOut};
  wire [2:0] nxtOuts = {next_blocked, next_trip, next_start};
  wire [2:0] rises = nxtOuts & ~curOuts;
  wire [2:0] falls = curOuts & ~nxtOuts;
  wire [2:0] maskOn = rises & {3{ctrl[UEG_F_STORE_ON]}};
  wire [2:0] maskOff = falls & {3{ctrl[UEG_F_STORE_OFF]}};

  always_ff @(posedge mclk) begin
    if (rst) begin
      startOut <= 1'b0;
      tripOut <= 1'b0;
      blockedOut <= 1'b0;
    end else if (tick) begin
      startOut <= next_start;
      tripOut <= next_trip;
      blockedOut <= next_blocked;
    end
  end

  // ----------------------------------------------------------------
  // Events: all edges of one cycle share the same stamp
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      eventStrobe <= 1'b0;
      eventOn <= 3'h0;
      eventOff <= 3'h0;
      eventStamp <= 32'h0;
      blockNotify <= 1'b0;
    end else begin
      eventStrobe <= tick && (maskOn != 3'h0 || maskOff != 3'h0);
      eventOn <= tick ? maskOn : 3'h0;
      eventOff <= tick ? maskOff : 3'h0;
      blockNotify <= tick && rises[2];
      if (tick) begin
        eventStamp <= msStamp;
      end
    end
  end

  // ----------------------------------------------------------------
  // ON-event log, oldest entry overwritten
  // ----------------------------------------------------------------
  // Field order: stamp, {group, id mask}, currents A-C, voltages AB-CA
  logic [31:0] logMem [0:11][0:7];
  logic [3:0] wrPtr;
  logic [3:0] logCount;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr <= 4'h0;
      logCount <= 4'h0;
    end else if (tick && rises != 3'h0) begin
      logMem[wrPtr][0] <= msStamp;
      logMem[wrPtr][1] <= {26'h0, settingGroup, rises};
      logMem[wrPtr][2] <= 32'(phaseACurrentRms);
      logMem[wrPtr][3] <= 32'(phaseBCurrentRms);
      logMem[wrPtr][4] <= 32'(phaseCCurrentRms);
      logMem[wrPtr][5] <= 32'(voltageAb);
      logMem[wrPtr][6] <= 32'(voltageBc);
      logMem[wrPtr][7] <= 32'(voltageCa);
      wrPtr <= (5'(wrPtr) == UEG_LOG_LAST) ? 4'h0 : wrPtr + 4'h1;
      if (logCount != UEG_LOG_DEPTH) begin
        logCount <= logCount + 4'h1;
      end
    end
  end

  // Entry logSel back from the newest, wrapping around the ring
  wire [4:0] backSum = 5'(wrPtr) + UEG_LOG_LAST - 5'(logSel);
  wire [4:0] rdIdx = (backSum > UEG_LOG_LAST) ? backSum - 5'(UEG_LOG_DEPTH) : backSum;
  wire [31:0] logWord = logMem[rdIdx[3:0]][addr[4:2]];

  // ----------------------------------------------------------------
  // Read-outs
  // ----------------------------------------------------------------
  wire [1:0] condCode = blockedOut ? UEG_COND_BLOCKED : tripOut ? UEG_COND_TRIP
    : startOut ? UEG_COND_START : UEG_COND_NORMAL;
  wire [19:0] remTime = (state == UEG_ARMING) ? 20'(actDelay) - 20'(timer) : 20'h0;
  wire [16:0] vRatio = ratioOf(posSeqVoltage, uvLimit);
  wire [16:0] iRatio = ratioOf(minCur, curLimit);
  wire [31:0] statusWord = {21'h0, settingGroup, blockedOut, tripOut, startOut, mode, condCode};

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (addr)
      UEG_A_CTRL: rdMux = {24'h0, ctrl};
      UEG_A_EDITGRP: rdMux = {29'h0, editGrp};
      UEG_A_UVLIM: rdMux = {16'h0, uvSet[editGrp]};
      UEG_A_CURLIM: rdMux = {26'h0, curSet[editGrp]};
      UEG_A_ACTDLY: rdMux = {13'h0, actSet[editGrp]};
      UEG_A_RELDLY: rdMux = {13'h0, relSet[editGrp]};
      UEG_A_STATUS: rdMux = statusWord;
      UEG_A_EXPTIME: rdMux = {13'h0, actDelay};
      UEG_A_REMTIME: rdMux = {{12{remTime[19]}}, remTime};
      UEG_A_VRATIO: rdMux = {15'h0, vRatio};
      UEG_A_IRATIO: rdMux = {15'h0, iRatio};
      UEG_A_LOGSEL: rdMux = {24'h0, logCount, logSel};
      default: begin
        if (addr[7:5] == UEG_A_LOGWIN && 4'(logSel) < logCount) begin
          rdMux = logWord;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rdEn ? rdMux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_trip_needs_start: assert property (tripOut |-> startOut)
    else $error("trip without start");
  chk_start_blk_excl: assert property (!(startOut && blockedOut))
    else $error("start and blocked together");
  chk_arm_to_start: assert property (
    tick && !modeOff && state == UEG_ARMING && uvCond && timer >= actDelay
    |=> state == UEG_STARTED)
    else $error("activation delay not honoured");
  chk_release_hold: assert property (
    tick && !modeOff && state == UEG_STARTED && relCond && relDelay != 19'h0
    |=> state == UEG_RELEASING && startCond)
    else $error("start released without delay");
  chk_block_drops: assert property (
    tick && !forceEn && blk |=> !startOut)
    else $error("start kept under blocking");
  chk_event_trip_on: assert property (
    eventOn[1] |-> eventStrobe && tripOut && $past(tick))
    else $error("trip ON event without trip");
  chk_log_ring: assert property (wrPtr < UEG_LOG_DEPTH && logCount <= UEG_LOG_DEPTH)
    else $error("log pointer out of range");
  chk_status_read: assert property (
    rdEn && addr == UEG_A_STATUS |=> rdata[1:0] == $past(condCode))
    else $error("condition read-back mismatch");

endmodule

//--- tb/ueg_relay_side.sv
/*
  Relay-side model: measurement chain with a refresh every tick, the
  blocking matrix line and an event buffer that keeps what it got.
  Assumes the bench commands it from mclk.
*/
`timescale 1ns/1ps
module ueg_relay_side #(
  parameter int TICK = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] cmdV,
  input wire logic [15:0] cmdIa,
  input wire logic [15:0] cmdIbc,
  input wire logic cmdBlock,
  input wire logic clr,
  input wire logic evStrobe,
  input wire logic [2:0] evOn,
  input wire logic [2:0] evOff,
  input wire logic notify,
  output logic [15:0] volt,
  output logic [15:0] ia,
  output logic [15:0] ibc,
  output logic blockOut,
  output logic [2:0] onSeen,
  output logic [2:0] offSeen,
  output logic notifySeen
);
  int cnt;
  // Values move only at refresh, never between, as the RMS chain does
  always_ff @(posedge mclk) begin
    cnt <= (rst || cnt == TICK - 1) ? 0 : cnt + 1;
    if (rst) begin
      volt <= 16'h1770;
      ia <= 16'h0000;
      ibc <= 16'h0000;
    end else if (cnt == TICK - 1) begin
      volt <= cmdV;
      ia <= cmdIa;
      ibc <= cmdIbc;
    end
  end
  // Bench raises blocking ahead of the blocked pick-up and once after start has risen
  always_ff @(posedge mclk) begin
    blockOut <= cmdBlock;
  end
  always_ff @(posedge mclk) begin
    if (rst || clr) begin
      onSeen <= 3'h0;
      offSeen <= 3'h0;
      notifySeen <= 1'h0;
    end else begin
      onSeen <= onSeen | (evStrobe ? evOn : 3'h0);
      offSeen <= offSeen | (evStrobe ? evOff : 3'h0);
      notifySeen <= notifySeen | notify;
    end
  end
endmodule

//--- tb/ueg_energize_block_tb.sv
/*
  Self-checking bench: register tasks, one task per scenario, report.
  Assumes the relay-side model supplies measurements and blocking.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module ueg_energize_block_tb;
  import ueg_pkg::*;
  localparam int T = 20;
  logic mclk, rst, wrEn, rdEn, blockIn, startOut, tripOut, blockedOut, eventStrobe, blockNotify, cmdBlock, clr;
  logic notifySeen;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, eventStamp, d, s0;
  logic [2:0] eventOn, eventOff, settingGroup, onSeen, offSeen;
  logic [15:0] cmdV, cmdIa, cmdIbc, volt, ia, ibc, vab;
  int failures, nCompared;

  ueg_energize_block #(.TICK_CYCLES(T), .MS_CYCLES(4)) uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .phaseACurrentRms(ia), .phaseBCurrentRms(ibc),
    .phaseCCurrentRms(ibc), .posSeqVoltage(volt), .voltageAb(vab), .voltageBc(vab), .voltageCa(vab),
    .settingGroup(settingGroup), .blockIn(blockIn), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .eventStrobe(eventStrobe), .eventOn(eventOn), .eventOff(eventOff),
    .eventStamp(eventStamp), .blockNotify(blockNotify));
  ueg_relay_side #(.TICK(T)) relay (.mclk(mclk), .rst(rst), .cmdV(cmdV), .cmdIa(cmdIa), .cmdIbc(cmdIbc),
    .cmdBlock(cmdBlock), .clr(clr), .evStrobe(eventStrobe), .evOn(eventOn), .evOff(eventOff),
    .notify(blockNotify), .volt(volt), .ia(ia), .ibc(ibc), .blockOut(blockIn), .onSeen(onSeen),
    .offSeen(offSeen), .notifySeen(notifySeen));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wrEn <= 1'h1;
    @(posedge mclk);
    wrEn <= 1'h0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'h1;
    @(posedge mclk);
    rdEn <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, d)
  endtask
  task automatic ticks(input int n);
    repeat (n * T) @(posedge mclk);
    #1;
  endtask
  task automatic meas(input logic [15:0] v, input logic [15:0] a, input logic [15:0] bc);
    @(posedge mclk);
    cmdV <= v;
    cmdIa <= a;
    cmdIbc <= bc;
  endtask
  task automatic blk(input logic b);
    @(posedge mclk);
    cmdBlock <= b;
  endtask
  task automatic clear_seen();
    @(posedge mclk);
    clr <= 1'h1;
    @(posedge mclk);
    clr <= 1'h0;
  endtask
  // w: 0 start, 1 trip, 2 blocked; bound in ticks
  task automatic wait_for(input int w, input logic v, input int n);
    int k;
    logic s;
    for (k = 0; k < n * T; k++) begin
      @(posedge mclk);
      #1 s = (w == 0) ? startOut : (w == 1) ? tripOut : blockedOut;
      if (s === v) return;
    end
    failures++;
    $display("mismatch wait output %0d exp %0h got %0h", w, v, s);
    report_and_stop();
  endtask
  task automatic idle();
    meas(16'h1770, 16'h0000, 16'h0000);
    blk(1'h0);
    ticks(10);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_and_clamp();
    rc(UEG_A_CTRL, 32'h000000C1, "ctrl");
    rc(UEG_A_UVLIM, 32'h00001388, "uv");
    rc(UEG_A_CURLIM, 32'h00000001, "cur");
    rc(UEG_A_ACTDLY, 32'h000003E8, "act");
    rc(UEG_A_RELDLY, 32'h00000032, "rel");
    rc(UEG_A_STATUS, 32'h00000004, "status");
    rc(8'hFC, 32'h00000000, "unmapped");
    wr(UEG_A_UVLIM, 32'h0000FFFF);
    rc(UEG_A_UVLIM, 32'h000026AC, "uv max");
    wr(UEG_A_CURLIM, 32'h00000000);
    rc(UEG_A_CURLIM, 32'h00000001, "cur min");
    wr(UEG_A_CURLIM, 32'h00000064);
    rc(UEG_A_CURLIM, 32'h0000003C, "cur max");
    wr(UEG_A_UVLIM, 32'h00000FA0);
    wr(UEG_A_CURLIM, 32'h00000001);
    wr(UEG_A_ACTDLY, 32'h00000003);
    wr(UEG_A_RELDLY, 32'h00000006);
  endtask
  task automatic sc_blocked_pickup();
    blk(1'h1);
    meas(16'h07D0, 16'h0064, 16'h0064);
    ticks(8);
    `CHK("start", 1'h0, startOut)
    `CHK("blocked", 1'h1, blockedOut)
    `CHK("trip", 1'h0, tripOut)
    rc(UEG_A_STATUS, 32'h00000087, "status blk");
    idle();
  endtask
  task automatic sc_activate_trip();
    clear_seen();
    meas(16'h07D0, 16'h0003, 16'h0064);
    ticks(3);
    `CHK("early start", 1'h0, startOut)
    rd(UEG_A_REMTIME);
    `CHK("remaining", 1'h1, d <= 32'h00000003)
    rc(UEG_A_EXPTIME, 32'h00000003, "exp time");
    wait_for(0, 1'h1, 4);
    s0 = eventStamp;
    ticks(2);
    `CHK("on start", 3'h1, onSeen)
    `CHK("one phase low", 1'h0, tripOut)
    rc(UEG_A_STATUS, 32'h00000025, "status start");
    rc(UEG_A_VRATIO, 32'h00000032, "v ratio");
    rc(UEG_A_IRATIO, 32'h0000003C, "i ratio");
    meas(16'h07D0, 16'h0064, 16'h0064);
    wait_for(1, 1'h1, 3);
    // Start and trip rise four 5 ms cycles apart
    `CHK("stamp step", 32'h00000014, eventStamp - s0)
    ticks(1);
    rc(UEG_A_STATUS, 32'h00000066, "status trip");
    // Release window after the blocked pick-up also logged a start ON
    rc(UEG_A_LOGSEL, 32'h00000040, "log count");
    rc(8'h44, 32'h00000002, "log id");
    rc(8'h48, 32'h00000064, "log ia");
    rc(8'h54, {16'h0000, vab}, "log uab");
  endtask
  task automatic sc_release();
    meas(16'h07D0, 16'h0000, 16'h0000);
    wait_for(1, 1'h0, 3);
    meas(16'h1770, 16'h0000, 16'h0000);
    ticks(2);
    `CHK("start held", 1'h1, startOut)
    meas(16'h1770, 16'h0064, 16'h0064);
    wait_for(1, 1'h1, 3);
    meas(16'h1770, 16'h0000, 16'h0000);
    wait_for(0, 1'h0, 10);
    ticks(1);
    `CHK("off events", 3'h3, offSeen)
  endtask
  task automatic sc_block_started();
    wr(UEG_A_CTRL, 32'h00000041);
    clear_seen();
    meas(16'h07D0, 16'h0000, 16'h0000);
    wait_for(0, 1'h1, 8);
    blk(1'h1);
    wait_for(0, 1'h0, 9);
    ticks(1);
    `CHK("blocked", 1'h1, blockedOut)
    `CHK("notify", 1'h1, notifySeen)
    `CHK("on only", 3'h5, onSeen)
    `CHK("off masked", 3'h0, offSeen)
    meas(16'h07D0, 16'h0064, 16'h0064);
    ticks(3);
    `CHK("no trip", 1'h0, tripOut)
    wr(UEG_A_CTRL, 32'h000000C1);
    idle();
  endtask
  task automatic sc_modes_force_group();
    for (int m = 1; m <= 5; m++) begin
      wr(UEG_A_CTRL, 32'h000000C0 | m);
      ticks(1);
      rd(UEG_A_STATUS);
      `CHK("mode", m[2:0], d[4:2])
    end
    for (int f = 0; f < 4; f++) begin
      wr(UEG_A_CTRL, 32'h000000C9 | (f << 4));
      ticks(2);
      rd(UEG_A_STATUS);
      `CHK("forced", f[1:0], d[1:0])
    end
    wr(UEG_A_CTRL, 32'h000000C1);
    @(posedge mclk);
    settingGroup <= 3'h3;
    ticks(2);
    rd(UEG_A_STATUS);
    `CHK("group", 3'h3, d[10:8])
    rc(UEG_A_EXPTIME, 32'h000003E8, "group exp");
    wr(UEG_A_EDITGRP, 32'h00000003);
    rc(UEG_A_UVLIM, 32'h00001388, "group uv");
  endtask

  initial begin
    failures = 0;
    nCompared = 0;
    rst = 1'h1;
    wrEn = 1'h0;
    rdEn = 1'h0;
    addr = 8'h00;
    wdata = 32'h00000000;
    settingGroup = 3'h0;
    vab = 16'h2B5C;
    cmdV = 16'h1770;
    cmdIa = 16'h0000;
    cmdIbc = 16'h0000;
    cmdBlock = 1'h0;
    clr = 1'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    sc_reset_and_clamp();
    sc_blocked_pickup();
    sc_activate_trip();
    sc_release();
    sc_block_started();
    sc_modes_force_group();
    report_and_stop();
  end
endmodule
